// File: bench/bdm_ctrl_props.sv
// Purpose: port-level properties of the debug access controller
// Assumes: init commands are issued only while the controller is idle
// Notes:   bound onto every bdm_ctrl instance
`timescale 1ns/1ps
`include "bdm_cfg.svh"
module bdm_ctrl_props #(
  parameter int                      NMEM     = 4,
  parameter logic [NMEM*`BDM_AW-1:0] MEM_LAST = '1
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [NMEM-1:0]       mem_en,
  input wire bdm_pkg::bdm_mem_req_t mem_req,
  input wire logic                  pass_flag
);
  logic [NMEM-1:0] oor;
  logic            init_wr;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  always_comb begin
    for (int i = 0; i < NMEM; i++)
      oor[i] = mem_req.addr > MEM_LAST[i*`BDM_AW +: `BDM_AW];
  end
  assign init_wr = psel && penable && pready && pwrite &&
                   paddr == `BDM_OFF_CMD && pwdata[0];
  sequence s_setup;
    psel && !penable;
  endsequence
  // a back-to-back exec after init may raise mem_en on the fourth edge
  sequence s_quiet;
    (mem_en == '0) [*3];
  endsequence
  property p_ready_next;
    s_setup |=> pready;
  endproperty
  property p_ready_access;
    pready |-> psel && penable;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  property p_oor_off;
    (mem_en & oor) == '0;
  endproperty
  property p_en_pulse;
    |mem_en |=> (mem_en == '0) [*2];
  endproperty
  property p_init_quiet;
    init_wr |=> s_quiet;
  endproperty
  property p_fail_src;
    $fell(pass_flag) |-> $past(|mem_en, 2) || $past(|mem_en, 3);
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("pready missing after setup");
  a_ready_access: assert property (p_ready_access)
    else $error("pready outside access");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
  a_oor_off: assert property (p_oor_off)
    else $error("memory enabled out of range");
  a_en_pulse: assert property (p_en_pulse)
    else $error("memory enable too close");
  a_init_quiet: assert property (p_init_quiet)
    else $error("init touched memory");
  a_fail_src: assert property (p_fail_src)
    else $error("pass flag fell without a read");
endmodule : bdm_ctrl_props
bind bdm_ctrl bdm_ctrl_props #(.NMEM(NMEM), .MEM_LAST(MEM_LAST)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .mem_en(mem_en), .mem_req(mem_req),
  .pass_flag(pass_flag));

// File: bench/bdm_mem_model.sv
// Purpose: behavioural memories behind the debug access controller
// Assumes: all memories start with the same address-derived content
// Notes:   read data lasts one cycle, then inverts every cycle
`timescale 1ns/1ps
`include "bdm_cfg.svh"
module bdm_mem_model #(
  parameter int NMEM = 4
) (
  input  wire logic                    pclk,
  input  wire logic [NMEM-1:0]         mem_en,
  input  wire bdm_pkg::bdm_mem_req_t   mem_req,
  output logic      [NMEM*`BDM_DW-1:0] mem_rdata
);
  logic [`BDM_DW-1:0] mem [NMEM][256];
  int                 last_mem;
  initial begin
    last_mem = 0;
    mem_rdata = '0;
    for (int i = 0; i < NMEM; i++)
      for (int a = 0; a < 256; a++)
        mem[i][a] = {~a[7:0], a[7:0]};
  end
  // stale data inverts every cycle, so it looks valid only on alternate cycles, in every memory
  always @(posedge pclk) begin
    for (int i = 0; i < NMEM; i++) begin
      if (mem_en[i] && mem_req.we) begin
        mem[i][mem_req.addr] <= mem_req.wdata;
        last_mem <= i;
      end
      if (mem_en[i] && !mem_req.we)
        mem_rdata[i*`BDM_DW +: `BDM_DW] <= mem[i][mem_req.addr];
      else
        mem_rdata[i*`BDM_DW +: `BDM_DW] <= ~mem_rdata[i*`BDM_DW +: `BDM_DW];
    end
  end
  function automatic logic [`BDM_DW-1:0] peek(input logic [7:0] a);
    return mem[last_mem][a];
  endfunction : peek
endmodule : bdm_mem_model

// File: bench/bist_debug_memory_access_test.sv
// Purpose: apb-driven checks of debug memory reads and writes
// Assumes: memory model holds {~addr, addr} until written
// Notes:   memory limits shrunk to 8'h3f so out-of-range is reachable
`timescale 1ns/1ps
`include "bdm_cfg.svh"
module bist_debug_memory_access_test;
  localparam int                      NMEM = 4;
  localparam logic [NMEM*`BDM_AW-1:0] LAST = {4{8'h3F}};
  logic                    pclk, presetn, psel, penable, pwrite, err;
  logic                    pready, pslverr, skip_init_in, pass_flag;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prdata, rd;
  logic [NMEM-1:0]         mem_en;
  logic [NMEM*`BDM_DW-1:0] mem_rdata;
  bdm_pkg::bdm_mem_req_t   mem_req;
  int                      errors, n_tests, n_en, n0;
  bdm_ctrl #(.NMEM(NMEM), .MEM_LAST(LAST)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .skip_init_in(skip_init_in),
    .mem_en(mem_en), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .pass_flag(pass_flag));
  bdm_mem_model #(.NMEM(NMEM)) u_mem (
    .pclk(pclk), .mem_en(mem_en), .mem_req(mem_req), .mem_rdata(mem_rdata));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (|mem_en)
      n_en <= n_en + 1;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // request held until pready is sampled high, released only after
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      finish_test();
    end
  endtask : apb
  task automatic idle();
    int k;
    for (k = 0; k < 40; k++) begin
      apb(1'b0, `BDM_OFF_STAT, 32'h0);
      if (rd[0] === 1'b0)
        break;
    end
    if (k == 40) begin
      errors++;
      finish_test();
    end
  endtask : idle
  task automatic cmd(input logic [2:0] c);
    apb(1'b1, `BDM_OFF_CMD, {29'h0, c});
    idle();
  endtask : cmd
  // one init then one exec, memory index 1 selected
  task automatic run(input logic [4:0] m, input logic [7:0] a,
                     input logic [15:0] d, input logic [7:0] cs);
    apb(1'b1, `BDM_OFF_CTRL, {19'h0, 8'h01, m});
    apb(1'b1, `BDM_OFF_ADDRA, {24'h0, a});
    apb(1'b1, `BDM_OFF_EXP, {16'h0, d});
    apb(1'b1, `BDM_OFF_WDAT, {16'h0, d});
    apb(1'b1, `BDM_OFF_CSTART, {24'h0, cs});
    apb(1'b1, `BDM_OFF_CEND, 32'h0000_001F);
    cmd(3'h1);
    cmd(3'h2);
  endtask : run
  task automatic cap();
    cmd(3'h4);
    apb(1'b0, `BDM_OFF_CHAIN, 32'h0);
  endtask : cap
  initial begin
    {presetn, psel, penable, pwrite, skip_init_in, err} = '0;
    {paddr, pwdata, rd} = '0;
    {errors, n_tests, n_en, n0} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk("pass reset", 32'h1, {31'h0, pass_flag});
    apb(1'b0, `BDM_OFF_STAT, 32'h0);
    chk("reinit reset", 32'h1, {31'h0, rd[4]});
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped err", 32'h1, {31'h0, err});
    cmd(3'h2);
    chk("exec before init", 32'h0, n_en);
    $display("test reset done");
    run(5'h03, 8'h04, 16'hA5A5, 8'h1E);
    chk("loc4", 32'h0000_A5A5, {16'h0, u_mem.peek(8'h04)});
    chk("loc5", 32'h0000_A5A5, {16'h0, u_mem.peek(8'h05)});
    chk("loc6", 32'h0000_F906, {16'h0, u_mem.peek(8'h06)});
    // register b with address-keyed data: wrdata xor address lands
    apb(1'b1, `BDM_OFF_ADDRB, 32'h0000_0010);
    run(5'h1B, 8'h04, 16'h00FF, 8'h1F);
    chk("loc10", 32'h0000_00EF, {16'h0, u_mem.peek(8'h10)});
    apb(1'b0, `BDM_OFF_WADDR, 32'h0);
    chk("addr b", 32'h0000_1104, {16'h0, rd[15:0]});
    $display("test block write done");
    run(5'h01, 8'h05, 16'h0000, 8'h1F);
    cap();
    chk("chain loc5", 32'h0000_A5A5, rd);
    chk("pass mismatch", 32'h0, {31'h0, pass_flag});
    apb(1'b1, `BDM_OFF_CHAIN, 32'h1);
    cmd(3'h2);
    cap();
    chk("chain loc6", 32'h0000_F906, rd);
    apb(1'b0, `BDM_OFF_WADDR, 32'h0);
    chk("next addr", 32'h7, {24'h0, rd[7:0]});
    $display("test repeat read done");
    run(5'h00, 8'h09, 16'h0000, 8'h1F);
    cap();
    chk("default addr", 32'h0000_FF00, rd);
    skip_init_in <= 1'b1;
    run(5'h00, 8'h09, 16'h0000, 8'h1F);
    cap();
    chk("pin skip", 32'h0000_F609, rd);
    skip_init_in <= 1'b0;
    run(5'h01, 8'h0A, 16'hF50A, 8'h1F);
    chk("pass match", 32'h1, {31'h0, pass_flag});
    cap();
    chk("chain match", 32'h0, rd);
    $display("test skip and match done");
    n0 = n_en;
    run(5'h01, 8'h40, 16'h0000, 8'h1F);
    chk("out of range", n0, n_en);
    run(5'h05, 8'h02, 16'h0000, 8'h1F);
    cap();
    apb(1'b1, `BDM_OFF_CHAIN, 32'h0);
    apb(1'b0, `BDM_OFF_STAT, 32'h0);
    chk("multi reinit", 32'h1, {31'h0, rd[4]});
    n0 = n_en;
    cmd(3'h2);
    chk("exec refused", n0, n_en);
    $display("test range and multi done");
    finish_test();
  end
endmodule : bist_debug_memory_access_test

// File: shared/bdm_cfg.svh
// Purpose: constants of the debug memory access block
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   definitions only
`ifndef BDM_CFG_SVH
`define BDM_CFG_SVH
`define BDM_AW         8
`define BDM_DW         16
`define BDM_CW         8
`define BDM_SELW       8
`define BDM_OFF_CTRL   12'h000
`define BDM_OFF_STAT   12'h004
`define BDM_OFF_ADDRA  12'h008
`define BDM_OFF_ADDRB  12'h00C
`define BDM_OFF_EXP    12'h010
`define BDM_OFF_WDAT   12'h014
`define BDM_OFF_CSTART 12'h018
`define BDM_OFF_CEND   12'h01C
`define BDM_OFF_CHAIN  12'h020
`define BDM_OFF_CMD    12'h024
`define BDM_OFF_WADDR  12'h028
`define BDM_CMD_INIT   0
`define BDM_CMD_EXEC   1
`define BDM_CMD_CAP    2
`define BDM_RST_ADDR   8'h00
`define BDM_RST_DATA   16'h0000
`define BDM_RST_CNT    8'h00
`endif

// File: shared/bdm_pkg.sv
// Purpose: types of the debug memory access block
// Assumes: widths from bdm_cfg.svh
// Notes:   no constants beyond the types
`include "bdm_cfg.svh"
package bdm_pkg;
  typedef struct packed {
    logic [`BDM_SELW-1:0] sel;
    logic                 addr_pat;
    logic                 use_b;
    logic                 multi;
    logic                 op_write;
    logic                 skip_init;
  } bdm_ctrl_t;

  typedef struct packed {
    logic                 we;
    logic [`BDM_AW-1:0]   addr;
    logic [`BDM_DW-1:0]   wdata;
  } bdm_mem_req_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ACC, ST_WAIT, ST_CMP, ST_DONE
  } bdm_state_t;
endpackage : bdm_pkg

// File: src/bdm_ctrl.sv
// Purpose: debug read/write of memories through the self-test controller
// Assumes: memories answer reads one cycle after the request flops
// Notes:   apb slave, no wait state on any access
//
// Summary of operation
// - disable a memory whose address range the step address exceeds.
// - out-of-range judged from step address range, not the selected memory.
// - algorithm may start from address loaded in register A or B, chosen by use_b.
// - skip-init bit or input keeps loaded address over algorithm defaults.
// - debug algorithms are built in; none downloaded here.
// - status chain mode shifts only the selected memory's status register.
// - status chain shifting leaves controller state untouched unless multi is set.
// - zero expected data leaves read content in status or signature.
// - mismatch clears pass flag and shows in status and signature.
// - read algorithm does one read then advances address by one.
// - defaults are address A zero and expected data zero.
// - init pass configures controller but does not run the algorithm.
// - exec pass runs programmed algorithm without reconfiguration.
// - init pass takes override start values for addresses, data, counter.
// - multi-memory shift-out destroys state; re-init needed before exec.
// - write one or many locations with run-time data pattern.
// - multi-location writes walk addresses; data may follow address.
// - expected and write data registers share one width.
`timescale 1ns/1ps
`include "bdm_cfg.svh"
module bdm_ctrl #(
  parameter int                 NMEM     = 4,
  parameter logic [NMEM*`BDM_AW-1:0] MEM_LAST = '1,
  parameter logic [NMEM-1:0]    IS_ROM   = '0
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 skip_init_in,
  output logic      [NMEM-1:0]      mem_en,
  output bdm_pkg::bdm_mem_req_t     mem_req,
  input  wire logic [NMEM*`BDM_DW-1:0] mem_rdata,
  output logic                      pass_flag
);
  localparam int AW = `BDM_AW;
  localparam int DW = `BDM_DW;
  localparam int CW = `BDM_CW;

  bdm_pkg::bdm_ctrl_t  ctrl_reg;
  bdm_pkg::bdm_state_t state_reg;
  logic [AW-1:0] seta_reg, setb_reg, adra_reg, adrb_reg;
  logic [DW-1:0] sexp_reg, swd_reg, exp_reg, wd_reg;
  logic [CW-1:0] scnt_reg, cend_reg, cnt_reg;
  logic [DW-1:0] chain_reg;
  logic [DW-1:0] stat_reg [NMEM];
  logic          skip_reg, reinit_reg, done_reg, fail_reg;
  // enables of the access just made: mem_en has already dropped in CMP
  logic [NMEM-1:0] hit_reg;
  logic [1:0]    skip_sync_reg;
  logic          ready_reg;
  logic [31:0]   rdata_reg;

  // apb decode
  wire acc_go = psel & penable & ready_reg;
  wire wr_go  = acc_go & pwrite;
  wire rd_go  = acc_go & ~pwrite;
  wire hit_ctrl  = paddr == `BDM_OFF_CTRL;
  wire hit_stat  = paddr == `BDM_OFF_STAT;
  wire hit_addra = paddr == `BDM_OFF_ADDRA;
  wire hit_addrb = paddr == `BDM_OFF_ADDRB;
  wire hit_exp   = paddr == `BDM_OFF_EXP;
  wire hit_wdat  = paddr == `BDM_OFF_WDAT;
  wire hit_cst   = paddr == `BDM_OFF_CSTART;
  wire hit_cend  = paddr == `BDM_OFF_CEND;
  wire hit_chain = paddr == `BDM_OFF_CHAIN;
  wire hit_cmd   = paddr == `BDM_OFF_CMD;
  wire hit_waddr = paddr == `BDM_OFF_WADDR;
  wire hit_any   = hit_ctrl | hit_stat | hit_addra | hit_addrb | hit_exp
                 | hit_wdat | hit_cst | hit_cend | hit_chain | hit_cmd
                 | hit_waddr;
  wire idle      = state_reg == bdm_pkg::ST_IDLE;
  wire cmd_wr    = wr_go & hit_cmd;
  // commands are ignored while an algorithm runs
  wire do_init   = cmd_wr & pwdata[`BDM_CMD_INIT] & idle;
  wire do_exec   = cmd_wr & pwdata[`BDM_CMD_EXEC] & idle
                 & ~pwdata[`BDM_CMD_INIT] & ~reinit_reg;
  wire do_cap    = cmd_wr & pwdata[`BDM_CMD_CAP] & idle;
  wire do_shift  = wr_go & hit_chain & idle;
  wire skip_now  = ctrl_reg.skip_init | skip_sync_reg[1];

  // selected memory index
  logic [$clog2(NMEM)-1:0] sel_idx;
  assign sel_idx = ctrl_reg.sel[$clog2(NMEM)-1:0];

  // working address and data pattern
  wire [AW-1:0] cur_addr = ctrl_reg.use_b ? adrb_reg : adra_reg;
  wire [DW-1:0] addr_pat = DW'(cur_addr);
  wire [DW-1:0] wr_val   = ctrl_reg.addr_pat ? (wd_reg ^ addr_pat)
                                              : wd_reg;
  wire          cnt_last = cnt_reg == cend_reg;

  // per-memory enable and compare
  logic [NMEM-1:0] en_next, miss;
  logic [DW-1:0]   diff [NMEM];
  genvar g;
  generate
    for (g = 0; g < NMEM; g++) begin : g_mem
      // step address range, not selection, decides the cut
      assign en_next[g] = (ctrl_reg.multi | (sel_idx == g))
                        & (cur_addr <= MEM_LAST[g*AW +: AW]);
      assign diff[g] = mem_rdata[g*DW +: DW] ^ exp_reg;
      assign miss[g] = hit_reg[g] & ~mem_req.we & (diff[g] != '0);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stat_reg[g] <= `BDM_RST_DATA;
        end else if (do_init) begin
          stat_reg[g] <= `BDM_RST_DATA;
        end else if (state_reg == bdm_pkg::ST_CMP && hit_reg[g]
                     && !mem_req.we) begin
          // rom keeps a rotating signature, ram the raw difference
          stat_reg[g] <= IS_ROM[g]
                       ? ({stat_reg[g][DW-2:0], stat_reg[g][DW-1]}
                          ^ diff[g])
                       : diff[g];
        end
      end
    end
  endgenerate

  wire cmp_fail = (state_reg == bdm_pkg::ST_CMP) & (miss != '0);

  // input pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_sync_reg <= 2'b00;
    end else begin
      skip_sync_reg <= {skip_sync_reg[0], skip_init_in};
    end
  end

  // apb handshake: no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg <= 1'b0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
    end else begin
      ready_reg <= psel & ~penable & ~ready_reg;
      pready    <= psel & ~penable & ~ready_reg;
      pslverr   <= psel & ~penable & ~ready_reg & ~hit_any;
      prdata    <= rdata_reg;
    end
  end

  // setup values written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '0;
      seta_reg <= `BDM_RST_ADDR;
      setb_reg <= `BDM_RST_ADDR;
      sexp_reg <= `BDM_RST_DATA;
      swd_reg  <= `BDM_RST_DATA;
      scnt_reg <= `BDM_RST_CNT;
      cend_reg <= `BDM_RST_CNT;
    end else if (wr_go && idle) begin
      if (hit_ctrl) begin
        ctrl_reg <= pwdata[$bits(bdm_pkg::bdm_ctrl_t)-1:0];
      end else if (hit_addra) begin
        seta_reg <= pwdata[AW-1:0];
      end else if (hit_addrb) begin
        setb_reg <= pwdata[AW-1:0];
      end else if (hit_exp) begin
        sexp_reg <= pwdata[DW-1:0];
      end else if (hit_wdat) begin
        swd_reg  <= pwdata[DW-1:0];
      end else if (hit_cst) begin
        scnt_reg <= pwdata[CW-1:0];
      end else if (hit_cend) begin
        cend_reg <= pwdata[CW-1:0];
      end
    end
  end

  // controller state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= bdm_pkg::ST_IDLE;
      adra_reg   <= `BDM_RST_ADDR;
      adrb_reg   <= `BDM_RST_ADDR;
      exp_reg    <= `BDM_RST_DATA;
      wd_reg     <= `BDM_RST_DATA;
      cnt_reg    <= `BDM_RST_CNT;
      skip_reg   <= 1'b0;
      reinit_reg <= 1'b1;
      done_reg   <= 1'b0;
      fail_reg   <= 1'b0;
      pass_flag  <= 1'b1;
      mem_en     <= '0;
      hit_reg    <= '0;
      mem_req    <= '0;
      chain_reg  <= `BDM_RST_DATA;
    end else begin
      case (state_reg)
        bdm_pkg::ST_IDLE: begin
          if (do_init) begin
            // load overrides only; nothing runs
            adra_reg   <= seta_reg;
            adrb_reg   <= setb_reg;
            exp_reg    <= sexp_reg;
            wd_reg     <= swd_reg;
            cnt_reg    <= scnt_reg;
            reinit_reg <= 1'b0;
            done_reg   <= 1'b0;
            fail_reg   <= 1'b0;
            pass_flag  <= 1'b1;
          end else if (do_exec) begin
            skip_reg  <= skip_now;
            if (!skip_now) begin
              adra_reg <= `BDM_RST_ADDR;
              exp_reg  <= `BDM_RST_DATA;
            end
            done_reg  <= 1'b0;
            state_reg <= bdm_pkg::ST_ACC;
          end else if (do_cap) begin
            chain_reg <= stat_reg[sel_idx];
          end else if (do_shift) begin
            chain_reg <= {pwdata[0], chain_reg[DW-1:1]};
            if (ctrl_reg.multi) begin
              // shared chain: shifting wrecks the working state
              adra_reg   <= `BDM_RST_ADDR;
              adrb_reg   <= `BDM_RST_ADDR;
              cnt_reg    <= `BDM_RST_CNT;
              reinit_reg <= 1'b1;
            end
          end
        end
        bdm_pkg::ST_ACC: begin
          mem_en        <= en_next;
          mem_req.we    <= ctrl_reg.op_write;
          mem_req.addr  <= cur_addr;
          mem_req.wdata <= wr_val;
          state_reg     <= bdm_pkg::ST_WAIT;
        end
        bdm_pkg::ST_WAIT: begin
          mem_en    <= '0;
          hit_reg   <= mem_en;
          state_reg <= bdm_pkg::ST_CMP;
        end
        bdm_pkg::ST_CMP: begin
          mem_req.we <= 1'b0;
          if (cmp_fail) begin
            fail_reg  <= 1'b1;
            pass_flag <= 1'b0;
          end
          // advance so the next exec reads the next word when use_b or skip-init is set
          if (ctrl_reg.use_b) begin
            adrb_reg <= adrb_reg + 1'b1;
          end else begin
            adra_reg <= adra_reg + 1'b1;
          end
          if (cnt_last) begin
            state_reg <= bdm_pkg::ST_DONE;
          end else begin
            cnt_reg   <= cnt_reg + 1'b1;
            state_reg <= bdm_pkg::ST_ACC;
          end
        end
        bdm_pkg::ST_DONE: begin
          // counter reloads so a repeated exec runs the same count
          cnt_reg   <= scnt_reg;
          done_reg  <= 1'b1;
          state_reg <= bdm_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= bdm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // read mux
  always_comb begin
    rdata_reg = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata_reg = 32'(ctrl_reg);
    end else if (hit_stat) begin
      rdata_reg = {26'h000_0000, skip_reg, reinit_reg, fail_reg,
                   pass_flag, done_reg, ~idle};
    end else if (hit_addra) begin
      rdata_reg = 32'(seta_reg);
    end else if (hit_addrb) begin
      rdata_reg = 32'(setb_reg);
    end else if (hit_exp) begin
      rdata_reg = 32'(sexp_reg);
    end else if (hit_wdat) begin
      rdata_reg = 32'(swd_reg);
    end else if (hit_cst) begin
      rdata_reg = 32'(scnt_reg);
    end else if (hit_cend) begin
      rdata_reg = 32'(cend_reg);
    end else if (hit_chain) begin
      rdata_reg = 32'(chain_reg);
    end else if (hit_waddr) begin
      rdata_reg = {16'h0000, 8'(adrb_reg), 8'(adra_reg)};
    end
  end
  wire unused_rd = rd_go;
endmodule : bdm_ctrl
